// ==== hw/scan_port_consts.svh ====
// Purpose: constants of the boundary-scan test access port
// Assumes: included by bare name
// Notes:   opcodes picked inside the 10-bit instruction space
`ifndef SCAN_PORT_CONSTS_SVH
`define SCAN_PORT_CONSTS_SVH
`define IR_LEN          10
`define IR_CAPTURE      10'h001
`define OP_EXTEST       10'h000
`define OP_SAMPLE       10'h001
`define OP_DEVICE_IDENTITY_WORD       10'h002
`define OP_USER_SIGNATURE_WORD     10'h003
`define OP_CFG_LOAD     10'h010
`define OP_ANALYZER     10'h020
`define OP_BYPASS       10'h3FF
`define ID_LEN          32
`define BSR_LEN_DEF     1164
`define CFG_WORD_LEN    8
`define CFG_FIFO_DEPTH  16
`define SYNC_RST_VAL    2'h0
`endif

// ==== hw/scan_port_pkg.sv ====
// Purpose: types of the boundary-scan test access port
// Assumes: nothing
// Notes:   gray codes along the usual walk of the controller
package scan_port_pkg;
   typedef enum logic [3:0] {
      tlr      = 4'h0,
      rti      = 4'h1,
      sel_dr   = 4'h3,
      cap_dr   = 4'h2,
      sh_dr    = 4'h6,
      ex1_dr   = 4'h7,
      upd_dr   = 4'h5,
      sel_ir   = 4'h4,
      cap_ir   = 4'hC,
      sh_ir    = 4'hD,
      ex1_ir   = 4'hF,
      upd_ir   = 4'hE,
      pause_dr = 4'hA,
      ex2_dr   = 4'hB,
      pause_ir = 4'h9,
      ex2_ir   = 4'h8
   } tap_state_t;
   typedef enum logic [2:0] {
      sel_bypass = 3'h0,
      sel_bsr    = 3'h1,
      sel_id     = 3'h2,
      sel_user   = 3'h3,
      sel_cfg    = 3'h4,
      sel_ana    = 3'h5
   } dr_sel_t;
endpackage

// ==== hw/cfg_fifo.sv ====
// Purpose: word fifo between scan port and configuration engine
// Assumes: one clock, synchronous reset copy
// Notes:   push ignored when full, pop ignored when empty
`timescale 1ns/1ps
module cfg_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != DEPTH[AW:0]);
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// ==== hw/scan_port.sv ====
// Purpose: boundary-scan test access port, sampled on the system clock
// Assumes: mclk at least eight times faster than tck
// Notes:   tck, tms, tdi pass two flops; tdo moves on tck falling edge
`timescale 1ns/1ps
`include "scan_port_consts.svh"
// How it works
// - pin scan testing runs before and after configuration; while loading it falls to bypass.
// - a configuration-load instruction routes shifted words into the configuration fifo.
// - sample/preload captures live pin values without touching the pins.
// - sample/preload also preloads the update stage; the analyzer has its own instruction.
// - extest drives the update stage onto the pins and captures the input pins.
// - bypass places a one-bit stage between tdi and tdo.
// - user_signature_word shifts a 32-bit user signature out on tdo.
// - device_identity_word shifts the 32-bit identity word out on tdo.
// - the instruction register is exactly ten bits long.
// - the boundary register length is a parameter, 1164 cells by default.
// - the identity word is version, part number, maker field and a fixed bit.
// - the identity word always ends in a one.
// - an analyzer instruction connects the internal analyzer chain to the port.
module scan_port #(
   parameter int          BSR_LEN      = `BSR_LEN_DEF,
   parameter logic [3:0]  ID_VERSION   = 4'hA,    // arbitrary
   parameter logic [15:0] ID_PART      = 16'h1234, // arbitrary
   parameter logic [10:0] ID_MAKER     = 11'h155, // arbitrary
   parameter logic [31:0] USER_SIG     = 32'h0000_0000
) (
   input  wire logic               mclk,
   input  wire logic               rst_n,
   input  wire logic               tck,
   input  wire logic               tms,
   input  wire logic               tdi,
   output logic                    tdo,
   output logic                    tdo_oe_n,
   input  wire logic               configuring,
   input  wire logic [BSR_LEN-1:0] pin_in,
   input  wire logic [BSR_LEN-1:0] core_out,
   output logic      [BSR_LEN-1:0] pin_out,
   output logic      [7:0]         cfg_data,
   output logic                    cfg_valid,
   input  wire logic               cfg_ready,
   output logic                    ana_select,
   output logic                    ana_capture,
   output logic                    ana_shift,
   output logic                    ana_update,
   output logic                    ana_tdi,
   input  wire logic               ana_tdo
);
   logic [1:0]             rst_sync;
   logic                   rst_q_n;
   logic                   tck_s1;
   logic                   tck_s2;
   logic                   tck_d;
   logic                   tms_s1;
   logic                   tms_s2;
   logic                   tdi_s1;
   logic                   tdi_s2;
   logic                   tck_rise;
   logic                   tck_fall;
   scan_port_pkg::tap_state_t state;
   scan_port_pkg::tap_state_t next_state;
   scan_port_pkg::dr_sel_t    dr_sel;
   logic [`IR_LEN-1:0]     ir_shift;
   logic [`IR_LEN-1:0]     scan_instruction_register;
   logic                   single_bit_passthrough;
   logic [`ID_LEN-1:0]     id_shift;
   logic [`ID_LEN-1:0]     device_identity_word;
   logic [`ID_LEN-1:0]     user_signature_word;
   logic [BSR_LEN-1:0]     bsr_shift;
   logic [BSR_LEN-1:0]     bsr_upd;
   logic [`CFG_WORD_LEN-1:0] cfg_shift;
   logic [2:0]             cfg_cnt;
   logic                   cfg_full;
   logic                   cfg_push_ready;
   logic                   drive_pins;
   logic                   next_tdo;
   localparam logic [2:0]  CFG_LAST = 3'(`CFG_WORD_LEN - 1);

   // reset release through two flops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync <= `SYNC_RST_VAL;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_q_n = rst_sync[1];

   // pin synchronisers
   // tms and tdi share the tck delay, so a detected rise sees them settled
   always_ff @(posedge mclk or negedge rst_q_n) begin
      if (!rst_q_n) begin
         tck_s1 <= 1'b0;
         tck_s2 <= 1'b0;
         tck_d  <= 1'b0;
         tms_s1 <= 1'b1;
         tms_s2 <= 1'b1;
         tdi_s1 <= 1'b1;
         tdi_s2 <= 1'b1;
      end else begin
         tck_s1 <= tck;
         tck_s2 <= tck_s1;
         tck_d  <= tck_s2;
         tms_s1 <= tms;
         tms_s2 <= tms_s1;
         tdi_s1 <= tdi;
         tdi_s2 <= tdi_s1;
      end
   end
   assign tck_rise = tck_s2 && !tck_d;
   assign tck_fall = !tck_s2 && tck_d;

   always_comb begin
      case (state)
         scan_port_pkg::tlr:      next_state = tms_s2 ? scan_port_pkg::tlr : scan_port_pkg::rti;
         scan_port_pkg::rti:      next_state = tms_s2 ? scan_port_pkg::sel_dr : scan_port_pkg::rti;
         scan_port_pkg::sel_dr:   next_state = tms_s2 ? scan_port_pkg::sel_ir : scan_port_pkg::cap_dr;
         scan_port_pkg::cap_dr:   next_state = tms_s2 ? scan_port_pkg::ex1_dr : scan_port_pkg::sh_dr;
         scan_port_pkg::sh_dr:    next_state = tms_s2 ? scan_port_pkg::ex1_dr : scan_port_pkg::sh_dr;
         scan_port_pkg::ex1_dr:   next_state = tms_s2 ? scan_port_pkg::upd_dr : scan_port_pkg::pause_dr;
         scan_port_pkg::pause_dr: next_state = tms_s2 ? scan_port_pkg::ex2_dr : scan_port_pkg::pause_dr;
         scan_port_pkg::ex2_dr:   next_state = tms_s2 ? scan_port_pkg::upd_dr : scan_port_pkg::sh_dr;
         scan_port_pkg::upd_dr:   next_state = tms_s2 ? scan_port_pkg::sel_dr : scan_port_pkg::rti;
         scan_port_pkg::sel_ir:   next_state = tms_s2 ? scan_port_pkg::tlr : scan_port_pkg::cap_ir;
         scan_port_pkg::cap_ir:   next_state = tms_s2 ? scan_port_pkg::ex1_ir : scan_port_pkg::sh_ir;
         scan_port_pkg::sh_ir:    next_state = tms_s2 ? scan_port_pkg::ex1_ir : scan_port_pkg::sh_ir;
         scan_port_pkg::ex1_ir:   next_state = tms_s2 ? scan_port_pkg::upd_ir : scan_port_pkg::pause_ir;
         scan_port_pkg::pause_ir: next_state = tms_s2 ? scan_port_pkg::ex2_ir : scan_port_pkg::pause_ir;
         scan_port_pkg::ex2_ir:   next_state = tms_s2 ? scan_port_pkg::upd_ir : scan_port_pkg::sh_ir;
         scan_port_pkg::upd_ir:   next_state = tms_s2 ? scan_port_pkg::sel_dr : scan_port_pkg::rti;
         default:                 next_state = scan_port_pkg::tlr;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_q_n) begin
      if (!rst_q_n) begin
         state <= scan_port_pkg::tlr;
      end else if (tck_rise) begin
         state <= next_state;
      end
   end

   // instruction register
   always_ff @(posedge mclk or negedge rst_q_n) begin
      if (!rst_q_n) begin
         ir_shift                  <= `IR_CAPTURE;
         scan_instruction_register <= `OP_DEVICE_IDENTITY_WORD;
      end else if (tck_rise) begin
         case (state)
            scan_port_pkg::tlr:    scan_instruction_register <= `OP_DEVICE_IDENTITY_WORD;
            scan_port_pkg::cap_ir: ir_shift <= `IR_CAPTURE;
            scan_port_pkg::sh_ir:  ir_shift <= {tdi_s2, ir_shift[`IR_LEN-1:1]};
            scan_port_pkg::upd_ir: scan_instruction_register <= ir_shift;
            default:               ir_shift <= ir_shift;
         endcase
      end
   end

   // instruction decode
   // while configuring, pin scan codes fall back to bypass
   always_comb begin
      case (scan_instruction_register)
         `OP_EXTEST:   dr_sel = configuring ? scan_port_pkg::sel_bypass
                                            : scan_port_pkg::sel_bsr;
         `OP_SAMPLE:   dr_sel = configuring ? scan_port_pkg::sel_bypass
                                            : scan_port_pkg::sel_bsr;
         `OP_DEVICE_IDENTITY_WORD:   dr_sel = scan_port_pkg::sel_id;
         `OP_USER_SIGNATURE_WORD: dr_sel = scan_port_pkg::sel_user;
         `OP_CFG_LOAD: dr_sel = scan_port_pkg::sel_cfg;
         `OP_ANALYZER: dr_sel = scan_port_pkg::sel_ana;
         default:      dr_sel = scan_port_pkg::sel_bypass;
      endcase
   end

   // identity and signature words are fixed at build time
   assign device_identity_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
   assign user_signature_word  = USER_SIG;

   // bypass and 32-bit signature registers
   always_ff @(posedge mclk or negedge rst_q_n) begin
      if (!rst_q_n) begin
         single_bit_passthrough <= 1'b0;
         id_shift               <= '0;
      end else if (tck_rise) begin
         if (state == scan_port_pkg::cap_dr) begin
            single_bit_passthrough <= 1'b0;
            id_shift <= (dr_sel == scan_port_pkg::sel_user) ? user_signature_word
                                                            : device_identity_word;
         end else if (state == scan_port_pkg::sh_dr) begin
            single_bit_passthrough <= tdi_s2;
            id_shift <= {tdi_s2, id_shift[`ID_LEN-1:1]};
         end
      end
   end

   // boundary register: capture and shift
   always_ff @(posedge mclk or negedge rst_q_n) begin
      if (!rst_q_n) begin
         bsr_shift <= '0;
      end else if (tck_rise && dr_sel == scan_port_pkg::sel_bsr) begin
         if (state == scan_port_pkg::cap_dr) begin
            bsr_shift <= pin_in;
         end else if (state == scan_port_pkg::sh_dr) begin
            if (BSR_LEN > 1) begin
               bsr_shift <= {tdi_s2, bsr_shift[BSR_LEN-1:1]};
            end else begin
               bsr_shift <= BSR_LEN'(tdi_s2);
            end
         end
      end
   end

   // update stage changes on the falling edge in update-dr
   always_ff @(posedge mclk or negedge rst_q_n) begin
      if (!rst_q_n) begin
         bsr_upd <= '0;
      end else if (tck_fall && state == scan_port_pkg::upd_dr
                   && dr_sel == scan_port_pkg::sel_bsr) begin
         bsr_upd <= bsr_shift;
      end
   end

   assign drive_pins = (scan_instruction_register == `OP_EXTEST) && !configuring;

   // one output mux per boundary cell
   genvar gi;
   generate
      for (gi = 0; gi < BSR_LEN; gi++) begin : g_cell
         assign pin_out[gi] = drive_pins ? bsr_upd[gi] : core_out[gi];
      end
   endgenerate

   // configuration words: held while the fifo refuses them
   // bits arriving while a word waits are dropped, not queued
   always_ff @(posedge mclk or negedge rst_q_n) begin
      if (!rst_q_n) begin
         cfg_shift <= '0;
         cfg_cnt   <= '0;
         cfg_full  <= 1'b0;
      end else begin
         if (cfg_full && cfg_push_ready) begin
            cfg_full <= 1'b0;
         end
         if (tck_rise && state == scan_port_pkg::sh_dr
             && dr_sel == scan_port_pkg::sel_cfg && !cfg_full) begin
            cfg_shift <= {tdi_s2, cfg_shift[`CFG_WORD_LEN-1:1]};
            cfg_cnt   <= cfg_cnt + 1'b1;
            if (cfg_cnt == CFG_LAST) begin
               cfg_full <= 1'b1;
            end
         end
      end
   end

   cfg_fifo #(
      .WIDTH (`CFG_WORD_LEN),
      .DEPTH (`CFG_FIFO_DEPTH)
   ) u_cfg_fifo (
      .clk       (mclk),
      .rst_n     (rst_q_n),
      .in_data   (cfg_shift),
      .in_valid  (cfg_full),
      .in_ready  (cfg_push_ready),
      .out_data  (cfg_data),
      .out_valid (cfg_valid),
      .out_ready (cfg_ready)
   );

   // analyzer chain hookup
   assign ana_select  = (dr_sel == scan_port_pkg::sel_ana);
   assign ana_capture = ana_select && tck_rise && state == scan_port_pkg::cap_dr;
   assign ana_shift   = ana_select && tck_rise && state == scan_port_pkg::sh_dr;
   assign ana_update  = ana_select && tck_fall && state == scan_port_pkg::upd_dr;
   assign ana_tdi     = tdi_s2;

   always_comb begin
      if (state == scan_port_pkg::sh_ir) begin
         next_tdo = ir_shift[0];
      end else begin
         case (dr_sel)
            scan_port_pkg::sel_bsr:  next_tdo = bsr_shift[0];
            scan_port_pkg::sel_id:   next_tdo = id_shift[0];
            scan_port_pkg::sel_user: next_tdo = id_shift[0];
            scan_port_pkg::sel_cfg:  next_tdo = cfg_full;
            scan_port_pkg::sel_ana:  next_tdo = ana_tdo;
            default:                 next_tdo = single_bit_passthrough;
         endcase
      end
   end

   // tdo and its enable move on the falling edge
   // enable off outside shift states, so the chain line is released
   always_ff @(posedge mclk or negedge rst_q_n) begin
      if (!rst_q_n) begin
         tdo      <= 1'b1;
         tdo_oe_n <= 1'b1;
      end else if (tck_fall) begin
         tdo      <= next_tdo;
         tdo_oe_n <= !(state == scan_port_pkg::sh_dr || state == scan_port_pkg::sh_ir);
      end
   end
endmodule

// ==== tb/scan_port_sva.sv ====
// Purpose: port checks of the scan port
// Assumes: bound onto scan_port, one clock domain
// Notes:   tdo side moves only while tck is low
`timescale 1ns/1ps
module scan_port_sva #(
   parameter int BSR_LEN = 8
) (
   input  wire logic               mclk,
   input  wire logic               rst_n,
   input  wire logic               tck,
   input  wire logic               tdi,
   input  wire logic               tdo,
   input  wire logic               tdo_oe_n,
   input  wire logic               configuring,
   input  wire logic [BSR_LEN-1:0] core_out,
   input  wire logic [BSR_LEN-1:0] pin_out,
   input  wire logic [7:0]         cfg_data,
   input  wire logic               cfg_valid,
   input  wire logic               cfg_ready,
   input  wire logic               ana_select,
   input  wire logic               ana_capture,
   input  wire logic               ana_shift,
   input  wire logic               ana_update,
   input  wire logic               ana_tdi
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_tck_low;
      !tck && !$past(tck);
   endsequence
   property p_tdo_on_fall;
      $changed(tdo) |-> s_tck_low;
   endproperty
   a_tdo_on_fall: assert property (p_tdo_on_fall)
      else $error("tdo moved while tck high");
   property p_oe_on_fall;
      $changed(tdo_oe_n) |-> s_tck_low;
   endproperty
   a_oe_on_fall: assert property (p_oe_on_fall)
      else $error("tdo enable moved while tck high");
   property p_reset_idle;
      $rose(rst_n) |-> (tdo && tdo_oe_n) [*2];
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("tdo driven right after reset");
   property p_busy_pins;
      configuring |-> pin_out == core_out;
   endproperty
   a_busy_pins: assert property (p_busy_pins)
      else $error("pins disturbed while configuring");
   property p_cfg_hold;
      cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_data);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold)
      else $error("config word lost while stalled");
   property p_shift_pulse;
      ana_shift |-> ana_select ##1 !ana_shift;
   endproperty
   a_shift_pulse: assert property (p_shift_pulse)
      else $error("analyzer shift pulse wrong");
   property p_cap_pulse;
      ana_capture |-> ana_select ##1 !ana_capture;
   endproperty
   a_cap_pulse: assert property (p_cap_pulse)
      else $error("analyzer capture pulse wrong");
   property p_upd_pulse;
      ana_update |-> ana_select && !tck ##1 !ana_update;
   endproperty
   a_upd_pulse: assert property (p_upd_pulse)
      else $error("analyzer update pulse wrong");
   property p_ana_tdi;
      ana_shift |-> ana_tdi == $past(tdi, 2);
   endproperty
   a_ana_tdi: assert property (p_ana_tdi)
      else $error("analyzer data in not the synced tdi");
endmodule

// ==== tb/jtag_host.sv ====
// Purpose: jtag host model driving the test pins
// Assumes: tasks entered at a rising mclk edge
// Notes:   tck 800 ns, still between frames
`timescale 1ns/1ps
module jtag_host (
   input  wire logic mclk,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h0;
   end
   task automatic step(input logic m, input logic d, output logic o);
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge mclk);
      #1 o = tdo;
      @(posedge mclk) tck <= 1'h1;
      repeat (3) @(posedge mclk);
      tck <= 1'h0;
   endtask
   // idle tdi flips so a stale level is never trusted
   task automatic mv(input logic m);
      logic o;
      step(m, ~tdi, o);
   endtask
   task automatic tap_reset;
      for (int i = 0; i < 5; i++) mv(1'h1);
      mv(1'h0);
   endtask
   task automatic scan(input logic ir, input int n, input logic [255:0] din,
                       output logic [255:0] dout);
      dout = '0;
      mv(1'h1);
      if (ir) mv(1'h1);
      mv(1'h0);
      mv(1'h0);
      for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
      mv(1'h1);
      mv(1'h0);
      // let the update edge land before callers look at outputs
      @(posedge mclk);
   endtask
endmodule

// ==== tb/scan_port_tb.sv ====
// Purpose: self-checking bench of the scan port
// Assumes: jtag_host as far side, short boundary register
// Notes:   tdo wire shows inverse of last level when released
`timescale 1ns/1ps
`include "scan_port_consts.svh"
module scan_port_tb;
   localparam int          BSR = 8;
   localparam logic [31:0] SIG = 32'hA5C3_0F96;
   localparam logic [31:0] ID  = {4'h3, 16'hBEEF, 11'h2AB, 1'h1}; // arbitrary
   logic           mclk, rst_n, tck, tms, tdi, tdo, tdo_oe_n, tdo_wire;
   logic           configuring, cfg_valid, cfg_ready, ana_tdo, ana_tdi;
   logic           ana_select, ana_capture, ana_shift, ana_update;
   logic [BSR-1:0] pin_in, core_out, pin_out;
   logic [7:0]     cfg_data;
   logic [255:0]   got;
   int             num_errors, checks;
   scan_port #(.BSR_LEN(BSR), .ID_VERSION(ID[31:28]), .ID_PART(ID[27:12]),
               .ID_MAKER(ID[11:1]), .USER_SIG(SIG)) uut (
      .mclk(mclk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdo_oe_n(tdo_oe_n), .configuring(configuring), .pin_in(pin_in),
      .core_out(core_out), .pin_out(pin_out), .cfg_data(cfg_data),
      .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .ana_select(ana_select),
      .ana_capture(ana_capture), .ana_shift(ana_shift), .ana_update(ana_update),
      .ana_tdi(ana_tdi), .ana_tdo(ana_tdo));
   assign tdo_wire = tdo_oe_n ? ~tdo : tdo;
   jtag_host host (.mclk(mclk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_wire));
   always #50 mclk = ~mclk;
   task automatic check(input string what, input logic [255:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      if (num_errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic ir(input logic [9:0] op);
      host.scan(1'h1, `IR_LEN, {246'h0, op}, got);
      check("ir capture", got[9:0], `IR_CAPTURE);
   endtask
   task automatic dr(input int n, input logic [255:0] din);
      host.scan(1'h0, n, din, got);
   endtask
   task automatic t_ident;
      check("oe after reset", tdo_oe_n, 1'h1);
      host.tap_reset();
      dr(32, '1);
      check("device_identity_word default", got[31:0], ID);
      ir(`OP_DEVICE_IDENTITY_WORD);
      dr(32, '0);
      check("device_identity_word", got[31:0], ID);
      ir(`OP_USER_SIGNATURE_WORD);
      dr(32, '0);
      check("user_signature_word", got[31:0], SIG);
   endtask
   task automatic t_bypass;
      ir(`OP_BYPASS);
      dr(4, 4'hB);
      check("bypass", got[3:0], 4'h6);
      ir(10'h155);
      dr(4, 4'hB);
      check("unassigned", got[3:0], 4'h6);
   endtask
   task automatic t_pins;
      pin_in <= 8'h3C;
      ir(`OP_SAMPLE);
      dr(BSR, 8'h96);
      check("sample capture", got[7:0], 8'h3C);
      check("sample pins", pin_out, core_out);
      ir(`OP_EXTEST);
      check("preload drive", pin_out, 8'h96);
      pin_in <= 8'hE1;
      dr(BSR, 8'h5A);
      check("extest capture", got[7:0], 8'hE1);
      check("extest drive", pin_out, 8'h5A);
      configuring <= 1'h1;
      dr(4, 4'hB);
      check("busy bypass", got[3:0], 4'h6);
      check("busy pins", pin_out, core_out);
      configuring <= 1'h0;
   endtask
   task automatic t_cfg;
      logic [255:0] w;
      w = '0;
      for (int k = 0; k < 17; k++) w[k*8 +: 8] = 8'h40 + 8'(k);
      ir(`OP_CFG_LOAD);
      dr(136, w);
      for (int k = 0; k < 17; k++) begin
         @(negedge mclk);
         check("cfg word", {cfg_valid, cfg_data}, {1'h1, w[k*8 +: 8]});
         @(posedge mclk) cfg_ready <= 1'h1;
         @(posedge mclk) cfg_ready <= 1'h0;
      end
      @(posedge mclk) cfg_ready <= 1'h1;
      repeat (4) @(posedge mclk);
      cfg_ready <= 1'h0;
      @(negedge mclk);
      check("cfg drained", cfg_valid, 1'h0);
      @(posedge mclk);
   endtask
   task automatic t_analyzer;
      ana_tdo <= 1'h1;
      ir(`OP_ANALYZER);
      check("ana select", ana_select, 1'h1);
      dr(4, 4'h0);
      check("ana chain", got[3:0], 4'hF);
      ana_tdo <= 1'h0;
   endtask
   initial begin
      mclk = 1'h0;
      rst_n = 1'h0;
      configuring = 1'h0;
      cfg_ready = 1'h0;
      ana_tdo = 1'h0;
      pin_in = 8'h00;
      core_out = 8'hC3;
      num_errors = 0;
      checks = 0;
      repeat (20) @(posedge mclk);
      rst_n <= 1'h1;
      repeat (4) @(posedge mclk);
      t_ident();
      t_bypass();
      t_pins();
      t_cfg();
      t_analyzer();
      complete_run();
   end
   initial begin
      #2_000_000;
      num_errors++;
      complete_run();
   end
endmodule
bind scan_port scan_port_sva #(.BSR_LEN(BSR_LEN)) u_sva (
   .mclk(mclk), .rst_n(rst_n), .tck(tck), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
   .configuring(configuring), .core_out(core_out), .pin_out(pin_out),
   .cfg_data(cfg_data), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready),
   .ana_select(ana_select), .ana_capture(ana_capture), .ana_shift(ana_shift),
   .ana_update(ana_update), .tdi(tdi), .ana_tdi(ana_tdi));
